//--- rtl/bse_pkg.sv
// Constants and types for the tester status and error insertion block
package bse_pkg;

	// ==========================================================
	// Register indices, byte address is four times the index
	localparam logic [7:0] IDX_CTRL = 8'h30;
	localparam logic [7:0] IDX_ERRCTL = 8'h32;
	localparam logic [7:0] IDX_AWC = 8'h33;
	localparam logic [7:0] IDX_LIVE = 8'h38;
	localparam logic [7:0] IDX_LAT = 8'h39;
	localparam logic [7:0] IDX_IE = 8'h3a;
	localparam logic [7:0] IDX_BITS0 = 8'h40;
	localparam logic [7:0] IDX_BITS3 = 8'h43;
	localparam logic [7:0] IDX_ERRS0 = 8'h44;
	localparam logic [7:0] IDX_ERRS2 = 8'h46;

	// ==========================================================
	// Field positions
	localparam int CTRL_LOAD_BIT = 0;
	localparam int CTRL_TXEN_BIT = 5;
	localparam int ERRCTL_SBE_BIT = 0;
	localparam int ST_LOCK = 0;
	localparam int ST_EOVF = 1;
	localparam int ST_BOVF = 2;
	localparam int ST_BERR = 3;
	localparam int ST_ZERO = 4;
	localparam int ST_ONES = 5;

	// ==========================================================
	// Reset values
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [3:0] ERRCTL_RST = 4'h0;
	localparam logic [7:0] AWC_RST = 8'h00;
	localparam logic [3:0] IE_RST = 4'h0;

	// ==========================================================
	// Pattern and detector counts
	localparam logic [2:0] PS_ALT_WORD = 3'h1;
	localparam logic [5:0] LOCK_MATCH_RUN = 6'h20;
	localparam logic [5:0] WINDOW_LAST = 6'h3f;
	localparam logic [2:0] WINDOW_ERR_LIMIT = 3'h6;
	localparam logic [5:0] SAME_RUN = 6'h20;
	localparam logic [3:0] WORD_LAST_BIT = 4'hf;

	// Automatic insertion intervals in generated bits
	localparam logic [23:0] IVL_1 = 24'h00_000a;
	localparam logic [23:0] IVL_2 = 24'h00_0064;
	localparam logic [23:0] IVL_3 = 24'h00_03e8;
	localparam logic [23:0] IVL_4 = 24'h00_2710;
	localparam logic [23:0] IVL_5 = 24'h01_86a0;
	localparam logic [23:0] IVL_6 = 24'h0f_4240;
	localparam logic [23:0] IVL_7 = 24'h98_9680;

	// ==========================================================
	// Alternating word phase
	typedef enum logic [1:0] {
		AW_LOW = 2'b01,
		AW_HIGH = 2'b10
	} bse_aw_type;

endpackage : bse_pkg

//--- rtl/bse_tester.sv
// Tester status, error insertion and alternating word logic
`timescale 1ns/10ps
module bse_tester
	import bse_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [9:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic [2:0] pattern_select_i,
	input wire logic [31:0] pattern_words_i,
	input wire logic pattern_load_i,
	input wire logic gen_bit_i,
	input wire logic gen_valid_i,
	output logic tx_bit_o,
	output logic tx_valid_o,
	input wire logic rx_bit_i,
	input wire logic rx_valid_i,
	input wire logic expected_bit_i,
	input wire logic tester_global_irq_en_i,
	output logic irq_o
);

	// ==========================================================
	// Helpers
	function automatic logic [23:0] rate_interval(input logic [2:0] code);
		logic [23:0] v;
		v = IVL_1;
		unique case (code)
			3'h1: v = IVL_1;
			3'h2: v = IVL_2;
			3'h3: v = IVL_3;
			3'h4: v = IVL_4;
			3'h5: v = IVL_5;
			3'h6: v = IVL_6;
			3'h7: v = IVL_7;
			default: v = IVL_1;
		endcase
		return v;
	endfunction : rate_interval

	function automatic logic is_index(input logic [9:0] adr,
		input logic [7:0] idx);
		return (adr[9:2] == idx);
	endfunction : is_index

	// ==========================================================
	// State
	typedef struct packed {
		logic ack;
		logic [7:0] rdata;
		logic [7:0] ctrl;
		logic [3:0] errctl;
		logic [7:0] awc;
		logic [3:0] ie;
		logic [5:0] lat;
		logic load_prev;
		logic sbe_prev;
		logic sbe_pend;
		logic [23:0] ins_cnt;
		logic locked;
		logic [5:0] match_cnt;
		logic [5:0] win_cnt;
		logic [2:0] win_err;
		logic [5:0] zrun;
		logic [5:0] orun;
		logic [31:0] bit_cnt;
		logic [23:0] err_cnt;
		logic bit_ovf;
		logic err_ovf;
		logic [31:0] bit_snap;
		logic [23:0] err_snap;
		bse_aw_type aw_phase;
		logic [3:0] aw_idx;
		logic [7:0] aw_rep;
		logic tx_bit;
		logic tx_valid;
	} bse_state_type;

	bse_state_type state_reg;
	bse_state_type state_next;

	// ==========================================================
	// Next state
	always_comb
	begin
		logic wr;
		logic [5:0] clr;
		logic [5:0] set;
		logic [5:0] live_now;
		logic [5:0] live_new;
		logic load_rise;
		logic bit_err;
		logic match;
		logic [2:0] werr;
		logic src_bit;
		logic flip;
		logic [7:0] rd;
		wr = 1'b0;
		clr = 6'h00;
		set = 6'h00;
		live_now = 6'h00;
		live_new = 6'h00;
		load_rise = 1'b0;
		bit_err = 1'b0;
		match = 1'b0;
		werr = 3'h0;
		src_bit = 1'b0;
		flip = 1'b0;
		rd = 8'h00;
		state_next = state_reg;

		// ======================================================
		// Bus slave
		state_next.ack = wb_cyc_i & wb_stb_i & ~state_reg.ack;
		wr = state_reg.ack & wb_cyc_i & wb_stb_i & wb_we_i & wb_sel_i[0];
		if (wr && is_index(wb_adr_i, IDX_CTRL))
		begin
			state_next.ctrl = wb_dat_i[7:0];
		end
		if (wr && is_index(wb_adr_i, IDX_ERRCTL))
		begin
			state_next.errctl = wb_dat_i[3:0];
		end
		if (wr && is_index(wb_adr_i, IDX_AWC))
		begin
			state_next.awc = wb_dat_i[7:0];
		end
		if (wr && is_index(wb_adr_i, IDX_IE))
		begin
			state_next.ie = wb_dat_i[3:0];
		end
		if (wr && is_index(wb_adr_i, IDX_LAT))
		begin
			clr = wb_dat_i[5:0];
		end

		// ======================================================
		// Counters and count load
		load_rise = state_reg.ctrl[CTRL_LOAD_BIT] & ~state_reg.load_prev;
		state_next.load_prev = state_reg.ctrl[CTRL_LOAD_BIT];
		match = (rx_bit_i == expected_bit_i);
		bit_err = rx_valid_i & state_reg.locked & ~match;
		if (load_rise)
		begin
			state_next.bit_snap = state_reg.bit_cnt;
			state_next.err_snap = state_reg.err_cnt;
			state_next.bit_cnt = 32'h0000_0000;
			state_next.err_cnt = 24'h00_0000;
			state_next.bit_ovf = 1'b0;
			state_next.err_ovf = 1'b0;
		end
		else
		begin
			if (rx_valid_i && !(&state_reg.bit_cnt))
			begin
				state_next.bit_cnt = state_reg.bit_cnt + 32'h0000_0001;
			end
			if (bit_err && !(&state_reg.err_cnt))
			begin
				state_next.err_cnt = state_reg.err_cnt + 24'h00_0001;
			end
			state_next.bit_ovf = state_reg.bit_ovf | (&state_next.bit_cnt);
			state_next.err_ovf = state_reg.err_ovf | (&state_next.err_cnt);
		end

		// ======================================================
		// Pattern lock
		if (rx_valid_i && !state_reg.locked)
		begin
			state_next.match_cnt = match ?
				state_reg.match_cnt + 6'h01 : 6'h00;
			if (state_next.match_cnt == LOCK_MATCH_RUN)
			begin
				state_next.locked = 1'b1;
				state_next.win_cnt = 6'h00;
				state_next.win_err = 3'h0;
			end
		end
		else if (rx_valid_i)
		begin
			werr = state_reg.win_err + {2'b00, bit_err};
			state_next.win_cnt = state_reg.win_cnt + 6'h01;
			if (werr >= WINDOW_ERR_LIMIT)
			begin
				state_next.locked = 1'b0;
				state_next.match_cnt = 6'h00;
			end
			else if (state_reg.win_cnt == WINDOW_LAST)
			begin
				state_next.win_err = 3'h0;
			end
			else
			begin
				state_next.win_err = werr;
			end
		end

		// ======================================================
		// All zeros and all ones runs
		if (rx_valid_i)
		begin
			if (rx_bit_i)
			begin
				state_next.zrun = 6'h00;
				if (state_reg.orun != SAME_RUN)
				begin
					state_next.orun = state_reg.orun + 6'h01;
				end
			end
			else
			begin
				state_next.orun = 6'h00;
				if (state_reg.zrun != SAME_RUN)
				begin
					state_next.zrun = state_reg.zrun + 6'h01;
				end
			end
		end

		// ======================================================
		// Live and latched status
		live_now = {state_reg.orun == SAME_RUN,
			state_reg.zrun == SAME_RUN, 1'b0,
			state_reg.bit_ovf, state_reg.err_ovf, state_reg.locked};
		live_new = {state_next.orun == SAME_RUN,
			state_next.zrun == SAME_RUN, 1'b0,
			state_next.bit_ovf, state_next.err_ovf, state_next.locked};
		set[ST_LOCK] = live_new[ST_LOCK] ^ live_now[ST_LOCK];
		set[ST_EOVF] = live_new[ST_EOVF] & ~live_now[ST_EOVF];
		set[ST_BOVF] = live_new[ST_BOVF] & ~live_now[ST_BOVF];
		set[ST_BERR] = bit_err;
		set[ST_ZERO] = live_new[ST_ZERO] & ~live_now[ST_ZERO];
		set[ST_ONES] = live_new[ST_ONES] & ~live_now[ST_ONES];
		state_next.lat = (state_reg.lat & ~clr) | set;

		// ======================================================
		// Alternating word generator
		if (pattern_load_i)
		begin
			state_next.aw_phase = AW_LOW;
			state_next.aw_idx = 4'h0;
			state_next.aw_rep = 8'h00;
		end
		else if (gen_valid_i && pattern_select_i == PS_ALT_WORD)
		begin
			state_next.aw_idx = state_reg.aw_idx + 4'h1;
			if (state_reg.aw_idx == WORD_LAST_BIT)
			begin
				if (state_reg.aw_rep == state_reg.awc)
				begin
					state_next.aw_rep = 8'h00;
					unique case (state_reg.aw_phase)
						AW_LOW: state_next.aw_phase = AW_HIGH;
						AW_HIGH: state_next.aw_phase = AW_LOW;
						default: state_next.aw_phase = AW_LOW;
					endcase
				end
				else
				begin
					state_next.aw_rep = state_reg.aw_rep + 8'h01;
				end
			end
		end
		if (pattern_select_i == PS_ALT_WORD)
		begin
			src_bit = pattern_words_i[{state_reg.aw_phase == AW_HIGH,
				state_reg.aw_idx}];
		end
		else
		begin
			src_bit = gen_bit_i;
		end

		// ======================================================
		// Error insertion
		state_next.sbe_prev = state_reg.errctl[ERRCTL_SBE_BIT];
		if (state_reg.errctl[ERRCTL_SBE_BIT] && !state_reg.sbe_prev)
		begin
			state_next.sbe_pend = 1'b1;
		end
		if (!state_reg.ctrl[CTRL_TXEN_BIT] || state_reg.errctl[3:1] == 3'h0)
		begin
			state_next.ins_cnt = 24'h00_0000;
		end
		else if (gen_valid_i)
		begin
			if (state_reg.ins_cnt ==
				rate_interval(state_reg.errctl[3:1]) - 24'h00_0001)
			begin
				state_next.ins_cnt = 24'h00_0000;
				flip = 1'b1;
			end
			else
			begin
				state_next.ins_cnt = state_reg.ins_cnt + 24'h00_0001;
			end
		end
		if (gen_valid_i && state_reg.ctrl[CTRL_TXEN_BIT] &&
			state_reg.sbe_pend)
		begin
			flip = 1'b1;
			state_next.sbe_pend = 1'b0;
		end
		state_next.tx_valid = gen_valid_i;
		if (gen_valid_i)
		begin
			state_next.tx_bit = src_bit ^ flip;
		end

		// ======================================================
		// Read data
		if (is_index(wb_adr_i, IDX_CTRL))
		begin
			rd = state_reg.ctrl;
		end
		else if (is_index(wb_adr_i, IDX_ERRCTL))
		begin
			rd = {4'h0, state_reg.errctl};
		end
		else if (is_index(wb_adr_i, IDX_AWC))
		begin
			rd = state_reg.awc;
		end
		else if (is_index(wb_adr_i, IDX_LIVE))
		begin
			rd = {2'b00, live_now};
		end
		else if (is_index(wb_adr_i, IDX_LAT))
		begin
			rd = {2'b00, state_reg.lat};
		end
		else if (is_index(wb_adr_i, IDX_IE))
		begin
			rd = {4'h0, state_reg.ie};
		end
		else if (wb_adr_i[9:2] >= IDX_BITS0 && wb_adr_i[9:2] <= IDX_BITS3)
		begin
			rd = state_reg.bit_snap[{wb_adr_i[3:2], 3'b000} +: 8];
		end
		else if (wb_adr_i[9:2] >= IDX_ERRS0 && wb_adr_i[9:2] <= IDX_ERRS2)
		begin
			rd = state_reg.err_snap[{wb_adr_i[3:2], 3'b000} +: 8];
		end
		if (state_next.ack)
		begin
			state_next.rdata = rd;
		end
	end

	// ==========================================================
	// Registers
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			state_reg <= '0;
			state_reg.ctrl <= CTRL_RST;
			state_reg.errctl <= ERRCTL_RST;
			state_reg.awc <= AWC_RST;
			state_reg.ie <= IE_RST;
			state_reg.aw_phase <= AW_LOW;
		end
		else
		begin
			state_reg <= state_next;
		end
	end

	// ==========================================================
	// Outputs
	assign wb_ack_o = state_reg.ack;
	assign wb_dat_o = {24'h00_0000, state_reg.rdata};
	assign tx_bit_o = state_reg.tx_bit;
	assign tx_valid_o = state_reg.tx_valid;
	assign irq_o = tester_global_irq_en_i &
		(|(state_reg.lat[3:0] & state_reg.ie));

endmodule : bse_tester

//--- testbench/bse_tester_monitor.sv
// Assertion checker for the tester status block
`timescale 1ns/10ps
module bse_monitor
	import bse_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire logic gen_valid_i,
	input wire logic tx_valid_o,
	input wire logic rx_valid_i,
	input wire logic tester_global_irq_en_i,
	input wire logic irq_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// ====
	// Bus and stream timing
	property p_ack;
		wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
	endproperty
	a_ack: assert property (p_ack) else $error("no ack");
	property p_ack_pulse;
		wb_ack_o |=> !wb_ack_o;
	endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
	property p_ack_req;
		$rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i);
	endproperty
	a_ack_req: assert property (p_ack_req) else $error("ack without request");
	property p_dat_hi;
		wb_ack_o |-> wb_dat_o[31:8] == 24'h00_0000;
	endproperty
	a_dat_hi: assert property (p_dat_hi) else $error("read upper bits");
	property p_txv;
		gen_valid_i |=> tx_valid_o;
	endproperty
	a_txv: assert property (p_txv) else $error("tx strobe missing");
	property p_txv_idle;
		!gen_valid_i |=> !tx_valid_o;
	endproperty
	a_txv_idle: assert property (p_txv_idle) else $error("tx strobe extra");
	property p_rst;
		$fell(rst_i) |-> !wb_ack_o && !tx_valid_o && !irq_o;
	endproperty
	a_rst: assert property (p_rst) else $error("outputs after reset");
	// ====
	// Interrupt
	property p_irq_glob;
		!tester_global_irq_en_i |-> !irq_o;
	endproperty
	a_irq_glob: assert property (p_irq_glob) else $error("irq ungated");
	property p_irq_cause;
		$rose(irq_o) |-> $past(wb_ack_o) || $past(rx_valid_i)
			|| $rose(tester_global_irq_en_i);
	endproperty
	a_irq_cause: assert property (p_irq_cause) else $error("irq no cause");
	c_irq: cover property ($rose(irq_o));
	c_irq_drop: cover property ($fell(irq_o));
	c_tx: cover property (tx_valid_o);
endmodule : bse_monitor
bind bse_tester bse_monitor i_mon (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
	.wb_dat_o, .wb_ack_o, .gen_valid_i, .tx_valid_o, .rx_valid_i,
	.tester_global_irq_en_i, .irq_o);

//--- testbench/testbench.sv
// Self-checking bench for the tester status block
`timescale 1ns/10ps
`define CHK(n, e, s) begin num_checks++; if ((s) !== (e)) begin fails++; \
$display("mismatch %s exp %h got %h", n, e, s); end end
module testbench
	import bse_pkg::*;
;
	logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, pl = 0, gb = 0;
	logic gv = 0, rb = 0, rv = 0, eb = 0, ge = 0, txb, txv, ack, irq;
	logic [2:0] ps = 3'h0;
	logic [7:0] adr = 8'h00, q;
	logic [31:0] wd = 32'h0000_0000, pw = 32'h0000_0000, rd;
	int fails = 0, num_checks = 0, cyc_n = 0, k;
	logic sq[$], tq[$];
	always #2.5 clk_i = ~clk_i;
	bse_tester i_dut (.clk_i, .rst_i, .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i({adr, 2'b00}), .wb_sel_i(4'hf),
		.wb_dat_i(wd), .wb_dat_o(rd), .wb_ack_o(ack),
		.pattern_select_i(ps), .pattern_words_i(pw), .pattern_load_i(pl),
		.gen_bit_i(gb), .gen_valid_i(gv), .tx_bit_o(txb), .tx_valid_o(txv),
		.rx_bit_i(rb), .rx_valid_i(rv), .expected_bit_i(eb),
		.tester_global_irq_en_i(ge), .irq_o(irq));
	always @(posedge clk_i) if (txv === 1'b1) tq.push_back(txb);
	// ====
	// Tasks
	task final_report();
		if (fails == 0 && num_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : final_report
	always @(posedge clk_i)
	begin
		cyc_n++;
		if (cyc_n == 60000)
		begin
			fails++;
			final_report();
		end
	end
	task wb(input logic w, input logic [7:0] a, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		cyc <= 1;
		stb <= 1;
		we <= w;
		adr <= a;
		wd <= {24'h00_0000, d};
		do @(posedge clk_i); while (ack !== 1'b1 && ++n < 20);
		q = rd[7:0];
		cyc <= 0;
		stb <= 0;
		@(posedge clk_i);
		if (n >= 20)
		begin
			fails++;
			final_report();
		end
	endtask : wb
	task rd_chk(input logic [7:0] a, input logic [7:0] e, input string n);
		wb(0, a, 8'h00);
		`CHK(n, e, q)
	endtask : rd_chk
	task rx(input logic b, input logic e, input int n);
		repeat (n)
		begin
			@(posedge clk_i);
			rv <= 1;
			rb <= b;
			eb <= e;
		end
		@(posedge clk_i);
		rv <= 0;
	endtask : rx
	task gen(input int n);
		logic b;
		repeat (n)
		begin
			@(posedge clk_i);
			b = 1'($urandom);
			gv <= 1;
			gb <= b;
			sq.push_back(b);
		end
		@(posedge clk_i);
		gv <= 0;
		repeat (2) @(posedge clk_i);
	endtask : gen
	task flips(input int e, input string n);
		int c;
		c = 0;
		`CHK("len", sq.size(), tq.size())
		foreach (sq[i]) c += (sq[i] !== tq[i]);
		`CHK(n, e, c)
		sq.delete();
		tq.delete();
	endtask : flips
	function logic aw_bit(int i, int n, logic [31:0] w);
		return w[(((i / 16) / (n + 1)) % 2) * 16 + i % 16];
	endfunction : aw_bit
	// ====
	// Main sequence
	initial
	begin
		void'($urandom(12));
		repeat (8) @(posedge clk_i);
		rst_i <= 0;
		rd_chk(IDX_AWC, AWC_RST, "awc rst");
		rd_chk(IDX_IE, 8'h00, "ie rst");
		rd_chk(8'h3b, 8'h00, "unmapped");
		rx(1, 0, 8);
		rd_chk(IDX_LAT, 8'h00, "err unlocked");
		rx(0, 0, 31);
		rd_chk(IDX_LIVE, 8'h00, "live 31");
		rx(0, 0, 1);
		rd_chk(IDX_LIVE, 8'h11, "live 32");
		rd_chk(IDX_LAT, 8'h11, "lat 32");
		rx(1, 1, 1);
		rd_chk(IDX_LIVE, 8'h01, "zero drop");
		rx(1, 1, 32);
		rd_chk(IDX_LIVE, 8'h21, "ones");
		ge <= 1;
		wb(1, IDX_IE, 8'h01);
		`CHK("irq en", 1'b1, irq)
		ge <= 0;
		@(posedge clk_i);
		`CHK("irq glob", 1'b0, irq)
		ge <= 1;
		wb(1, IDX_IE, 8'h0f);
		wb(1, IDX_LAT, 8'h01);
		rd_chk(IDX_LAT, 8'h30, "w1c");
		`CHK("irq zo", 1'b0, irq)
		rx(1, 0, 1);
		rx(0, 0, 1);
		wb(1, IDX_LAT, 8'h00);
		rd_chk(IDX_LAT, 8'h38, "berr");
		`CHK("irq berr", 1'b1, irq)
		wb(1, IDX_IE, 8'h07);
		`CHK("irq ie off", 1'b0, irq)
		wb(1, IDX_IE, 8'h0f);
		wb(1, IDX_LAT, 8'h3f);
		rd_chk(IDX_LAT, 8'h00, "clr");
		`CHK("irq clr", 1'b0, irq)
		wb(1, IDX_CTRL, 8'h01);
		wb(1, IDX_CTRL, 8'h00);
		k = 64 + $urandom % 20;
		rx(0, 0, k);
		wb(1, IDX_CTRL, 8'h01);
		rd_chk(IDX_BITS0, k[7:0], "bits");
		rd_chk(IDX_ERRS0, 8'h00, "errs");
		wb(1, IDX_CTRL, 8'h00);
		rx(1, 0, 5);
		rd_chk(IDX_LIVE, 8'h01, "lock 5");
		wb(1, IDX_CTRL, 8'h01);
		rd_chk(IDX_ERRS0, 8'h05, "errs 5");
		rd_chk(IDX_BITS0, 8'h05, "bits 5");
		wb(1, IDX_LAT, 8'h3f);
		rx(0, 1, 64);
		rd_chk(IDX_LIVE, 8'h10, "lost");
		rd_chk(IDX_LAT, 8'h19, "lost lat");
		`CHK("irq lost", 1'b1, irq)
		k = $urandom % 3;
		wb(1, IDX_AWC, k[7:0]);
		rd_chk(IDX_AWC, k[7:0], "awc");
		wb(1, IDX_CTRL, 8'h20);
		ps <= PS_ALT_WORD;
		pw <= $urandom;
		pl <= 1;
		@(posedge clk_i);
		pl <= 0;
		gen(64 * (k + 1));
		sq.delete();
		for (int i = 0; i < 64 * (k + 1); i++) sq.push_back(aw_bit(i, k, pw));
		flips(0, "aw");
		ps <= 3'h0;
		for (int r = 1; r < 5; r++)
		begin
			wb(1, IDX_ERRCTL, 8'h00);
			wb(1, IDX_ERRCTL, 8'(r << 1));
			gen(3 * 10 ** r);
			flips(3, "auto");
		end
		wb(1, IDX_ERRCTL, 8'h00);
		wb(1, IDX_AWC, 8'h05);
		gen(20);
		flips(0, "rate 0");
		wb(1, IDX_ERRCTL, 8'h01);
		gen(20);
		flips(1, "sbe");
		gen(20);
		flips(0, "sbe hold");
		wb(1, IDX_ERRCTL, 8'h02);
		wb(1, IDX_CTRL, 8'h00);
		gen(30);
		flips(0, "tx off");
		final_report();
	end
endmodule : testbench
